// [bench/tiop_monitor.sv]
`default_nettype none
module tiop_monitor
  import tiop_pkg::*;
#(
  parameter logic [tiop_pkg::PIN_W-1:0] LINK_PINS = 32'h0000_000c
) (
  input  wire logic                           clk_i,
  input  wire logic                           arst_n_i,
  input  wire logic                           psel_i,
  input  wire logic                           penable_i,
  input  wire logic [tiop_pkg::ADDR_W-1:0]    paddr_i,
  input  wire logic [tiop_pkg::DATA_W-1:0]    prdata_o,
  input  wire logic                           pready_o,
  input  wire logic                           pslverr_o,
  input  wire logic                           link_en_i,
  input  wire logic [tiop_pkg::PIN_W-1:0]     pin_o,
  input  wire logic [tiop_pkg::PIN_W-1:0]     pin_oe_o,
  input  wire logic [tiop_pkg::NUM_PORTS-1:0] strobe_output_qualifier_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import tiop_pkg::*;

  default clocking mon_cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // Two phases of one bus transfer
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_access;
    psel_i && penable_i;
  endsequence

  // Zero wait states, errors only off the map
  chk_ready_high: assert property (s_access |-> pready_o)
    else $error("pready low in access phase");
  chk_unmapped_err: assert property (
    s_setup ##1 (psel_i && penable_i && paddr_i[11:9] != 3'h0)
    |-> pslverr_o)
    else $error("no error on unmapped address");
  chk_count_ok: assert property (
    s_setup ##1 (psel_i && penable_i && paddr_i == 12'h00c)
    |-> !pslverr_o)
    else $error("counter read refused");
  // Read data only moves at a setup edge
  chk_rdata_hold: assert property (
    !$past(psel_i && !penable_i) |-> $stable(prdata_o))
    else $error("read data moved outside setup");
  // Pads never carry a high level unless driven
  chk_od_low: assert property ((pin_o & ~pin_oe_o) == '0)
    else $error("pin value without enable");
  chk_link_free: assert property (
    link_en_i [*2] |-> (pin_oe_o & LINK_PINS) == '0)
    else $error("port drives link pins");
  chk_reset_idle: assert property (
    $rose(arst_n_i) |-> pin_oe_o == '0 && strobe_output_qualifier_o == '0)
    else $error("pins active after reset");
  chk_strobe_pins: assert property (
    $rose(strobe_output_qualifier_o[4]) |-> ##[0:2] pin_oe_o[31])
    else $error("strobe without output data");
endmodule // tiop_monitor

bind tiop_top tiop_monitor #(
  .LINK_PINS(LINK_PINS)
) tiop_monitor_inst (
  .clk_i                     (clk_i),
  .arst_n_i                  (arst_n_i),
  .psel_i                    (psel_i),
  .penable_i                 (penable_i),
  .paddr_i                   (paddr_i),
  .prdata_o                  (prdata_o),
  .pready_o                  (pready_o),
  .pslverr_o                 (pslverr_o),
  .link_en_i                 (link_en_i),
  .pin_o                     (pin_o),
  .pin_oe_o                  (pin_oe_o),
  .strobe_output_qualifier_o (strobe_output_qualifier_o)
);
`default_nettype wire

// [bench/tiop_partner.sv]
`default_nettype none
module tiop_partner
  import tiop_pkg::*;
(
  input  wire logic                           clk_i,
  input  wire logic [tiop_pkg::PIN_W-1:0]     dev_o_i,
  input  wire logic [tiop_pkg::PIN_W-1:0]     dev_oe_i,
  output logic [tiop_pkg::PIN_W-1:0]          pad_o,
  output logic [tiop_pkg::NUM_PORTS-1:0]      rdy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import tiop_pkg::*;

  logic [PIN_W-1:0]     val_q = '0;
  logic [PIN_W-1:0]     en_q = '0;
  logic [NUM_PORTS-1:0] rdy_q = '0;

  // Pull-downs: a pin nobody drives reads low
  assign pad_o = (dev_oe_i & dev_o_i) | (~dev_oe_i & en_q & val_q);
  assign rdy_o = rdy_q;

  // Strobe changes together with the data it qualifies
  task automatic drive(input logic [31:0] v, input logic [31:0] e,
                       input logic [4:0] r);
    @(posedge clk_i);
    val_q <= v;
    en_q <= e;
    rdy_q <= r;
  endtask

  // Application clock on pin 0, still between bursts
  task automatic pulse(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge clk_i);
      val_q[0] <= 1'b1;
      repeat (4) @(posedge clk_i);
      val_q[0] <= 1'b0;
    end
  endtask
endmodule // tiop_partner
`default_nettype wire

// [bench/tiop_top_bench.sv]
`default_nettype none
module tiop_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tiop_pkg::*;

  logic                 clk = 1'b0;
  logic                 arst_n = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic                 link_en = 1'b0;
  logic [ADDR_W-1:0]    paddr = '0;
  logic [DATA_W-1:0]    pwdata = '0;
  logic [DATA_W-1:0]    prdata, rd, c1;
  logic                 pready, pslverr;
  logic [PIN_W-1:0]     pin_i, pin_o, pin_oe;
  logic [NUM_PORTS-1:0] ready_in, strobe;
  int                   mismatches = 0;
  int                   comparisons = 0;

  // Half period of the 125 MHz clock
  always #4 clk = ~clk;

  tiop_top tiop_top_inst (
    .clk_i                     (clk),
    .arst_n_i                  (arst_n),
    .psel_i                    (psel),
    .penable_i                 (penable),
    .pwrite_i                  (pwrite),
    .paddr_i                   (paddr),
    .pwdata_i                  (pwdata),
    .prdata_o                  (prdata),
    .pready_o                  (pready),
    .pslverr_o                 (pslverr),
    .link_en_i                 (link_en),
    .pin_i                     (pin_i),
    .pin_o                     (pin_o),
    .pin_oe_o                  (pin_oe),
    .ready_in_i                (ready_in),
    .strobe_output_qualifier_o (strobe)
  );

  tiop_partner tiop_partner_inst (
    .clk_i    (clk),
    .dev_o_i  (pin_o),
    .dev_oe_i (pin_oe),
    .pad_o    (pin_i),
    .rdy_o    (ready_in)
  );

  function automatic logic [11:0] pa(input int i, input logic [4:0] o);
    return {REGION_PORT, 3'(i), o};
  endfunction
  function automatic logic [11:0] cba(input int j);
    return {REGION_CB, 3'(j), OFF_CB_CFG};
  endfunction

  task automatic check(input logic [31:0] g, input logic [31:0] e,
                       input string m);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, m, g, e);
    end
  endtask

  // One transfer; held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdv(input logic [11:0] a, input logic [31:0] e,
                     input string m);
    apb(1'b0, a, '0);
    check(rd, e, m);
  endtask
  // Reads status until rx valid shows, bounded
  task automatic poll(input logic [11:0] a, input int n);
    for (int k = 0; k < n; k++)
    begin
      apb(1'b0, a, '0);
      if (rd[STAT_RXV_BIT] === 1'b1)
        break;
    end
  endtask
  // Pads sampled mid-cycle, away from the launching edge
  task automatic wait_pin(input logic [31:0] m, input logic [31:0] eo,
                          input logic [31:0] ev);
    for (int k = 0; k < 40; k++)
    begin
      @(negedge clk);
      if ((pin_oe & m) === eo && (pin_o & m) === ev)
        break;
    end
    check(pin_oe & m, eo, "pin enable");
    check(pin_o & m, ev, "pin value");
  endtask

  task automatic t_reset();
    rdv(pa(4, OFF_CTRL), 32'h0, "ctrl reset");
    rdv(pa(0, OFF_COUNT), 32'h0, "count reset");
    rdv(cba(0), 32'h0, "cb0 reset");
    $display("test reset done");
  endtask

  task automatic t_map();
    wr(cba(5), 32'h0000_0301);
    rdv(cba(5), 32'h0000_0301, "cb5 cfg");
    wr(cba(0), 32'h0000_0301);
    rdv(cba(0), 32'h0, "cb0 fixed");
    apb(1'b0, cba(6), '0);
    check({31'h0, pslverr}, 32'h1, "cb6 absent");
    apb(1'b0, 12'h200, '0);
    check({31'h0, pslverr}, 32'h1, "unmapped");
    check(rd, 32'h0, "unmapped data");
    $display("test map done");
  endtask

  task automatic t_out();
    wr(pa(4, OFF_CTRL), 32'h23);
    wr(pa(4, OFF_DATA), 32'ha5c3_0f96);
    // Strobe lasts one block period, so look every cycle
    for (int k = 0; k < 10; k++)
    begin
      @(negedge clk);
      if (strobe[4] === 1'b1)
        break;
    end
    check({31'h0, strobe[4]}, 32'h1, "ready-out");
    wait_pin('1, '1, 32'ha5c3_0f96);
    apb(1'b0, pa(4, OFF_COUNT), '0);
    c1 = rd;
    apb(1'b0, pa(4, OFF_COUNT), '0);
    check({31'h0, (rd - c1) inside {2, 3}}, 32'h1, "count step");
    apb(1'b0, pa(4, OFF_TSTAMP), '0);
    check({31'h0, rd != 0 && rd < c1}, 32'h1, "stamp");
    wr(pa(4, OFF_CTRL), 32'h07);
    wr(pa(4, OFF_DATA), 32'h0000_ffff);
    wait_pin('1, 32'hffff_0000, '0);
    $display("test output done");
  endtask

  task automatic t_share();
    wr(pa(4, OFF_CTRL), 32'h03);
    wr(pa(4, OFF_DATA), '1);
    wr(pa(0, OFF_CTRL), 32'h03);
    wr(pa(0, OFF_DATA), 32'h0);
    wait_pin('1, '1, 32'hffff_fffe);
    @(posedge clk);
    link_en <= 1'b1;
    wait_pin(32'hd, 32'h1, 32'h0);
    @(posedge clk);
    link_en <= 1'b0;
    wr(pa(0, OFF_CTRL), 32'h0);
    wr(pa(4, OFF_CTRL), 32'h0);
    $display("test share done");
  endtask

  task automatic t_in();
    tiop_partner_inst.drive(32'h5a, 32'hff, 5'h00);
    wr(pa(2, OFF_CTRL), 32'h11);
    wr(pa(2, OFF_DATA), 32'h1234_5678);
    rdv(pa(2, OFF_DATA), 32'h0, "input data");
    @(negedge clk);
    check(pin_oe & 32'hff, 32'h0, "input drives");
    poll(pa(2, OFF_STATUS), 8);
    check(rd & 32'h1, 32'h0, "no ready-in");
    tiop_partner_inst.drive(32'h5a, 32'hff, 5'h04);
    poll(pa(2, OFF_STATUS), 20);
    check(rd & 32'h1, 32'h1, "ready-in");
    rdv(pa(2, OFF_DATA), 32'h5a5a_5a5a, "word in");
    wr(pa(2, OFF_COND), 32'h77);
    wr(pa(2, OFF_CTRL), 32'h19);
    poll(pa(2, OFF_STATUS), 8);
    check(rd & 32'h1, 32'h0, "cond wait");
    tiop_partner_inst.drive(32'h77, 32'hff, 5'h04);
    poll(pa(2, OFF_STATUS), 20);
    rdv(pa(2, OFF_DATA), 32'h7777_7777, "cond word");
    wr(pa(2, OFF_CTRL), 32'h0);
    $display("test input done");
  endtask

  // Divide by two: eight source edges give four counts
  task automatic t_clk();
    wr(cba(1), 32'h0000_0101);
    wr(pa(4, OFF_CTRL), 32'h0000_0101);
    tiop_partner_inst.drive('0, 32'h1, 5'h00);
    apb(1'b0, pa(4, OFF_COUNT), '0);
    c1 = rd;
    tiop_partner_inst.pulse(8);
    rdv(pa(4, OFF_COUNT), c1 + 32'h4, "ext ticks");
    wr(pa(4, OFF_CTRL), 32'h0);
    $display("test clock block done");
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Run is a few hundred cycles; this is ample
  initial
  begin
    #400us;
    mismatches++;
    $display("watchdog expired");
    summarize();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_map();
    t_out();
    t_share();
    t_in();
    t_clk();
    summarize();
  end
endmodule // tiop_top_bench
`default_nettype wire

// [src/tiop_pkg.sv]
`default_nettype none
package tiop_pkg;

  // Port population and widths
  localparam int unsigned NUM_PORTS = 5;
  localparam int unsigned NUM_CB    = 6;
  localparam int unsigned PIN_W     = 32;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned CNT_W     = 16;
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned SHN_W     = 6;
  localparam int unsigned PORT_W [NUM_PORTS] = '{1, 4, 8, 16, 32};

  // Reference tick: 100 ticks per 125 system cycles
  localparam int unsigned CLK_MHZ   = 125;
  localparam int unsigned REF_MHZ   = 100;
  localparam int unsigned ACC_W     = 8;
  localparam logic [ACC_W:0] REF_INC = (ACC_W+1)'(REF_MHZ);
  localparam logic [ACC_W:0] CLK_LIM = (ACC_W+1)'(CLK_MHZ);

  // Address map: [11:8] region, [7:5] index, [4:0] register offset
  localparam int unsigned REGION_LSB = 8;
  localparam int unsigned IDX_LSB    = 5;
  localparam int unsigned IDX_W      = 3;
  localparam int unsigned OFF_W      = 5;
  localparam logic [3:0] REGION_PORT = 4'h0;
  localparam logic [3:0] REGION_CB   = 4'h1;
  localparam logic [OFF_W-1:0] OFF_CTRL   = 5'h00;
  localparam logic [OFF_W-1:0] OFF_DATA   = 5'h04;
  localparam logic [OFF_W-1:0] OFF_COND   = 5'h08;
  localparam logic [OFF_W-1:0] OFF_COUNT  = 5'h0c;
  localparam logic [OFF_W-1:0] OFF_TSTAMP = 5'h10;
  localparam logic [OFF_W-1:0] OFF_TIME   = 5'h14;
  localparam logic [OFF_W-1:0] OFF_STATUS = 5'h18;
  localparam logic [OFF_W-1:0] OFF_CB_CFG = 5'h00;

  // Port control fields
  localparam int unsigned CTRL_W          = 8;
  localparam int unsigned CTRL_EN_BIT     = 0;
  localparam int unsigned CTRL_OUT_BIT    = 1;
  localparam int unsigned CTRL_OD_BIT     = 2;
  localparam int unsigned CTRL_COND_BIT   = 3;
  localparam int unsigned CTRL_RDYIN_BIT  = 4;
  localparam int unsigned CTRL_RDYOUT_BIT = 5;
  localparam int unsigned CB_SEL_LSB      = 8;
  localparam int unsigned CB_SEL_W        = 3;
  localparam logic [CB_SEL_W-1:0] CB_SEL_RESET = 3'h0;

  // Status fields
  localparam int unsigned STAT_RXV_BIT   = 0;
  localparam int unsigned STAT_XFULL_BIT = 1;
  localparam int unsigned STAT_TARM_BIT  = 2;
  localparam int unsigned STAT_BUSY_BIT  = 3;

  // Clock block configuration fields
  localparam int unsigned CB_SRC_BIT = 0;
  localparam int unsigned CB_DIV_LSB = 8;
  localparam int unsigned DIV_W      = 8;

  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [SHN_W-1:0] SHN_ONE = 6'h01;
  localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;

  function automatic logic [DATA_W-1:0] port_mask(input int unsigned w);
    port_mask = (w >= DATA_W) ? '1 : ((32'h1 << w) - 32'h1);
  endfunction

  typedef struct packed {
    logic [CTRL_W-1:0]   ctrl;
    logic [CB_SEL_W-1:0] cb;
    logic [DATA_W-1:0]   cond;
    logic [DATA_W-1:0]   xfer;
    logic [DATA_W-1:0]   shift;
    logic [SHN_W-1:0]    nshift;
    logic                xfull;
    logic                busy;
    logic                rxv;
    logic [CNT_W-1:0]    cnt;
    logic [CNT_W-1:0]    tstamp;
    logic [CNT_W-1:0]    ttime;
    logic                tarmed;
    logic [DATA_W-1:0]   pout;
    logic                rdy_out;
  } tiop_port_s;

  typedef struct packed {
    logic             src;
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] dcnt;
    logic             tick;
  } tiop_cb_s;

  typedef struct packed {
    tiop_port_s [NUM_PORTS-1:0] ports;
    tiop_cb_s [NUM_CB-1:0]      cbs;
    logic [ACC_W-1:0]           acc;
    logic                       ref_tick;
    logic [PIN_W-1:0]           pin_s1;
    logic [PIN_W-1:0]           pin_s2;
    logic                       clk_pin_q;
    logic [NUM_PORTS-1:0]       rdy_s1;
    logic [NUM_PORTS-1:0]       rdy_s2;
    logic [PIN_W-1:0]           pin_o;
    logic [PIN_W-1:0]           pin_oe;
    logic [DATA_W-1:0]          prdata;
    logic                       pslverr;
  } tiop_state_s;

endpackage
`default_nettype wire

// [src/tiop_top.sv]
// The register addresses and the APB register port were left to the implementer.
`default_nettype none
module tiop_top
  import tiop_pkg::*;
#(
  parameter logic [tiop_pkg::PIN_W-1:0] LINK_PINS = 32'h0000_000c
) (
  input  wire logic                           clk_i,
  input  wire logic                           arst_n_i,
  input  wire logic                           psel_i,
  input  wire logic                           penable_i,
  input  wire logic                           pwrite_i,
  input  wire logic [tiop_pkg::ADDR_W-1:0]    paddr_i,
  input  wire logic [tiop_pkg::DATA_W-1:0]    pwdata_i,
  output logic [tiop_pkg::DATA_W-1:0]         prdata_o,
  output logic                                pready_o,
  output logic                                pslverr_o,
  input  wire logic                           link_en_i,
  input  wire logic [tiop_pkg::PIN_W-1:0]     pin_i,
  output logic [tiop_pkg::PIN_W-1:0]          pin_o,
  output logic [tiop_pkg::PIN_W-1:0]          pin_oe_o,
  input  wire logic [tiop_pkg::NUM_PORTS-1:0] ready_in_i,
  output logic [tiop_pkg::NUM_PORTS-1:0]      strobe_output_qualifier_o
);
  import tiop_pkg::*;

  tiop_state_s s_q;
  tiop_state_s s_d;

  logic [3:0]            reg_region;
  logic [IDX_W-1:0]      reg_idx;
  logic [OFF_W-1:0]      reg_off;
  logic                  rd_setup;
  logic                  wr_access;
  logic                  dec_err;
  logic [DATA_W-1:0]     rd_data;
  logic [NUM_PORTS-1:0]  act;
  logic                  pin_rise;
  logic                  ev;
  logic [ACC_W:0]        acc_sum;
  logic                  tk;
  logic                  tok;
  logic                  accept;
  logic [DATA_W-1:0]     m;
  logic [DATA_W-1:0]     samp;
  logic [DATA_W-1:0]     nsh;
  logic [SHN_W-1:0]      n;
  logic                  emit;
  logic                  found;
  logic [IDX_W-1:0]      own;
  logic                  dbit;
  logic                  port_hit;
  logic                  cb_hit;

  // Field split of the bus address; low two bits decoded as part of the offset
  assign reg_region = paddr_i[REGION_LSB +: 4];
  assign reg_idx    = paddr_i[IDX_LSB +: IDX_W];
  assign reg_off    = paddr_i[0 +: OFF_W];
  assign rd_setup   = psel_i & ~penable_i;
  assign wr_access  = psel_i & penable_i & pwrite_i;
  assign port_hit   = (reg_region == REGION_PORT)
                    && (reg_idx < IDX_W'(NUM_PORTS));
  assign cb_hit     = (reg_region == REGION_CB)
                    && (reg_idx < IDX_W'(NUM_CB));

  // Zero wait states: every access ends in its first access cycle
  assign pready_o  = 1'b1;
  assign prdata_o  = s_q.prdata;
  assign pslverr_o = s_q.pslverr;
  assign pin_o     = s_q.pin_o;
  assign pin_oe_o  = s_q.pin_oe;

  // Ready-out strobes, one per port
  always_comb
  begin
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      strobe_output_qualifier_o[i] = s_q.ports[i].rdy_out;
    end
  end

  // Read mux and decode; captured at setup so access data is stable
  always_comb
  begin
    rd_data = '0;
    dec_err = 1'b0;
    if (port_hit)
    begin
      if (reg_off == OFF_CTRL)
      begin
        rd_data[0 +: CTRL_W]            = s_q.ports[reg_idx].ctrl;
        rd_data[CB_SEL_LSB +: CB_SEL_W] = s_q.ports[reg_idx].cb;
      end
      else if (reg_off == OFF_DATA)
        rd_data = s_q.ports[reg_idx].xfer;
      else if (reg_off == OFF_COND)
        rd_data = s_q.ports[reg_idx].cond;
      else if (reg_off == OFF_COUNT)
        rd_data[0 +: CNT_W] = s_q.ports[reg_idx].cnt;
      else if (reg_off == OFF_TSTAMP)
        rd_data[0 +: CNT_W] = s_q.ports[reg_idx].tstamp;
      else if (reg_off == OFF_TIME)
        rd_data[0 +: CNT_W] = s_q.ports[reg_idx].ttime;
      else if (reg_off == OFF_STATUS)
      begin
        rd_data[STAT_RXV_BIT]   = s_q.ports[reg_idx].rxv;
        rd_data[STAT_XFULL_BIT] = s_q.ports[reg_idx].xfull;
        rd_data[STAT_TARM_BIT]  = s_q.ports[reg_idx].tarmed;
        rd_data[STAT_BUSY_BIT]  = s_q.ports[reg_idx].busy;
      end
      else
        dec_err = 1'b1;
    end
    else if (cb_hit)
    begin
      if (reg_off == OFF_CB_CFG)
      begin
        rd_data[CB_SRC_BIT]            = s_q.cbs[reg_idx].src;
        rd_data[CB_DIV_LSB +: DIV_W]   = s_q.cbs[reg_idx].div;
      end
      else
        dec_err = 1'b1;
    end
    else
      dec_err = 1'b1;
  end

  // Whole next-state computation
  always_comb
  begin
    s_d      = s_q;
    acc_sum  = '0;
    ev       = 1'b0;
    tk       = 1'b0;
    tok      = 1'b0;
    accept   = 1'b0;
    m        = '0;
    samp     = '0;
    nsh      = '0;
    n        = '0;
    emit     = 1'b0;
    found    = 1'b0;
    own      = '0;
    dbit     = 1'b0;
    act      = '0;

    // Two-stage synchronisers for pins and ready-in strobes
    s_d.pin_s1    = pin_i;
    s_d.pin_s2    = s_q.pin_s1;
    s_d.clk_pin_q = s_q.pin_s2[0];
    s_d.rdy_s1    = ready_in_i;
    s_d.rdy_s2    = s_q.rdy_s1;
    pin_rise      = s_q.pin_s2[0] & ~s_q.clk_pin_q;

    // Fractional reference tick, average 100 MHz from 125 MHz
    acc_sum = {1'b0, s_q.acc} + REF_INC;
    if (acc_sum >= CLK_LIM)
    begin
      s_d.acc      = ACC_W'(acc_sum - CLK_LIM);
      s_d.ref_tick = 1'b1;
    end
    else
    begin
      s_d.acc      = acc_sum[ACC_W-1:0];
      s_d.ref_tick = 1'b0;
    end

    // Clock blocks; block 0 is locked to the reference tick
    for (int j = 0; j < NUM_CB; j++)
    begin
      ev = (j != 0 && s_q.cbs[j].src) ? pin_rise : s_q.ref_tick;
      if (ev)
      begin
        if (s_q.cbs[j].dcnt >= s_q.cbs[j].div)
        begin
          s_d.cbs[j].tick = 1'b1;
          s_d.cbs[j].dcnt = '0;
        end
        else
        begin
          s_d.cbs[j].tick = 1'b0;
          s_d.cbs[j].dcnt = s_q.cbs[j].dcnt + DIV_ONE;
        end
      end
      else
        s_d.cbs[j].tick = 1'b0;
      if (wr_access && cb_hit && reg_off == OFF_CB_CFG
          && reg_idx == IDX_W'(j) && j != 0)
      begin
        s_d.cbs[j].src  = pwdata_i[CB_SRC_BIT];
        s_d.cbs[j].div  = pwdata_i[CB_DIV_LSB +: DIV_W];
        s_d.cbs[j].dcnt = '0;
      end
    end

    // Per-port datapath
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      m = port_mask(PORT_W[i]);
      n = SHN_W'(DATA_W / PORT_W[i]);
      act[i] = s_q.ports[i].ctrl[CTRL_EN_BIT]
             && !(link_en_i && |(m & LINK_PINS));
      emit = 1'b0;

      // Read of data clears valid before the tick, so a new word wins
      if (rd_setup && port_hit && reg_idx == IDX_W'(i)
          && reg_off == OFF_DATA)
        s_d.ports[i].rxv = 1'b0;

      tk = act[i] && s_q.cbs[s_q.ports[i].cb].tick;
      if (tk)
      begin
        s_d.ports[i].cnt = s_q.ports[i].cnt + CNT_ONE;
        tok = !s_q.ports[i].tarmed
            || s_q.ports[i].cnt == s_q.ports[i].ttime;
        // Direction bit selects one path for the whole port
        if (s_q.ports[i].ctrl[CTRL_OUT_BIT])
        begin
          if (s_q.ports[i].busy)
          begin
            s_d.ports[i].pout   = s_q.ports[i].shift & m;
            s_d.ports[i].shift  = s_q.ports[i].shift >> PORT_W[i];
            s_d.ports[i].nshift = s_q.ports[i].nshift - SHN_ONE;
            s_d.ports[i].busy   = s_q.ports[i].nshift != SHN_ONE;
            emit = 1'b1;
          end
          else if (s_q.ports[i].xfull && tok)
          begin
            s_d.ports[i].pout   = s_q.ports[i].xfer & m;
            s_d.ports[i].shift  = s_q.ports[i].xfer >> PORT_W[i];
            s_d.ports[i].nshift = n - SHN_ONE;
            s_d.ports[i].busy   = n > SHN_ONE;
            s_d.ports[i].xfull  = 1'b0;
            s_d.ports[i].tstamp = s_q.ports[i].cnt;
            s_d.ports[i].tarmed = 1'b0;
            emit = 1'b1;
          end
          s_d.ports[i].rdy_out = emit
                               && s_q.ports[i].ctrl[CTRL_RDYOUT_BIT];
        end
        else
        begin
          // Full width always sampled, even on pins owned elsewhere
          samp = s_q.pin_s2 & m;
          accept = (!s_q.ports[i].ctrl[CTRL_RDYIN_BIT]
                    || s_q.rdy_s2[i])
                && (s_q.ports[i].nshift != '0
                    || (tok && (!s_q.ports[i].ctrl[CTRL_COND_BIT]
                        || samp == (s_q.ports[i].cond & m))));
          s_d.ports[i].rdy_out = 1'b0;
          if (accept)
          begin
            nsh = (s_q.ports[i].shift >> PORT_W[i])
                | (samp << (DATA_W - PORT_W[i]));
            s_d.ports[i].shift = nsh;
            if (s_q.ports[i].nshift == n - SHN_ONE)
            begin
              s_d.ports[i].xfer   = nsh;
              s_d.ports[i].rxv    = 1'b1;
              s_d.ports[i].nshift = '0;
              s_d.ports[i].tstamp = s_q.ports[i].cnt;
              s_d.ports[i].tarmed = 1'b0;
            end
            else
              s_d.ports[i].nshift = s_q.ports[i].nshift + SHN_ONE;
          end
        end
      end

      // Register writes land after the tick; in output mode a fresh word refills buffer
      if (wr_access && port_hit && reg_idx == IDX_W'(i))
      begin
        if (reg_off == OFF_CTRL)
        begin
          s_d.ports[i].ctrl    = pwdata_i[0 +: CTRL_W];
          if (pwdata_i[CB_SEL_LSB +: CB_SEL_W] < CB_SEL_W'(NUM_CB))
            s_d.ports[i].cb    = pwdata_i[CB_SEL_LSB +: CB_SEL_W];
          s_d.ports[i].busy    = 1'b0;
          s_d.ports[i].nshift  = '0;
          s_d.ports[i].xfull   = 1'b0;
          s_d.ports[i].rxv     = 1'b0;
          s_d.ports[i].rdy_out = 1'b0;
        end
        else if (reg_off == OFF_DATA && s_q.ports[i].ctrl[CTRL_OUT_BIT])
        begin
          s_d.ports[i].xfer  = pwdata_i;
          s_d.ports[i].xfull = 1'b1;
        end
        else if (reg_off == OFF_COND)
          s_d.ports[i].cond = pwdata_i;
        else if (reg_off == OFF_TIME)
        begin
          s_d.ports[i].ttime  = pwdata_i[0 +: CNT_W];
          s_d.ports[i].tarmed = 1'b1;
        end
      end
    end

    // Pin ownership: widest first, so the narrowest active port wins
    for (int p = 0; p < PIN_W; p++)
    begin
      found = 1'b0;
      own   = '0;
      for (int i = NUM_PORTS - 1; i >= 0; i--)
      begin
        if (act[i] && p < PORT_W[i])
        begin
          found = 1'b1;
          own   = IDX_W'(i);
        end
      end
      dbit = s_q.ports[own].pout[p];
      if (found && s_q.ports[own].ctrl[CTRL_OUT_BIT])
      begin
        if (s_q.ports[own].ctrl[CTRL_OD_BIT])
        begin
          s_d.pin_o[p]  = 1'b0;
          s_d.pin_oe[p] = ~dbit;
        end
        else
        begin
          s_d.pin_o[p]  = dbit;
          s_d.pin_oe[p] = 1'b1;
        end
      end
      else
      begin
        s_d.pin_o[p]  = 1'b0;
        s_d.pin_oe[p] = 1'b0;
      end
    end

    // Bus answer registered in setup, shown during access
    if (rd_setup)
    begin
      s_d.prdata  = rd_data;
      s_d.pslverr = dec_err;
    end
  end

  // State register; all-zero reset puts every port on block 0
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

endmodule // tiop_top
`default_nettype wire
